// [core/nps_regs.sv]
`timescale 1ns/1ps
`default_nettype none
`include "nps_map.svh"
module nps_regs (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // i/o bus
  input wire logic [3:0] ioAddr,
  input wire logic [7:0] ioWrData,
  input wire logic ioWrite,
  input wire logic ioRead,
  output logic [7:0] ioRdData,
  // execution context
  input wire logic execInBoot,
  input wire logic progPortActive,
  // page buffer and target section
  input wire logic pageBufWrite,
  input wire logic pageBufInBoot,
  input wire logic targetIsApp,
  // memory engine
  input wire logic flashBusyIn,
  input wire logic eepromBusyIn,
  input wire logic opDone,
  input wire logic opFailed,
  input wire logic locUpdate,
  input wire logic [15:0] locUpdateAddr,
  output nps_pkg::nps_cmd_type cmdCode,
  output logic cmdStart,
  // memory read and fetch paths
  input wire logic memRdBoot,
  input wire logic [7:0] memRdData,
  input wire logic memFetchBoot,
  input wire logic [15:0] memFetchWord,
  output logic [7:0] gatedRdData,
  output logic [15:0] gatedFetchWord,
  // interrupt
  output logic irqRequest
);
  import nps_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // state

  nps_lock_type lockState;
  nps_lock_type next_lockState;
  logic appGuard;
  logic flashBusyFlag;
  logic eeBusyFlag;
  logic writeFault;
  logic next_writeFault;
  logic readyIrqEnable;
  logic readyFlag;
  logic next_readyFlag;
  logic [15:0] writeValue;
  logic [15:0] targetLocation;
  logic bufUsed;
  logic bufInBoot;
  logic bufMixed;

  nps_guard_if gif ();

  ////////////////////////////////////////////////////////////////////////
  // write decode

  function automatic logic hitWrite(input logic [3:0] a,
                                    input logic [3:0] ofs,
                                    input logic we);
    hitWrite = we && (a == ofs);
  endfunction

  wire wrCommand = hitWrite(ioAddr, `NPS_OFS_COMMAND, ioWrite);
  wire wrProt = hitWrite(ioAddr, `NPS_OFS_PROT, ioWrite);
  wire wrIrqEn = hitWrite(ioAddr, `NPS_OFS_IRQ_EN, ioWrite);
  wire wrIrqPend = hitWrite(ioAddr, `NPS_OFS_IRQ_PEND, ioWrite);
  wire wrDataLo = hitWrite(ioAddr, `NPS_OFS_DATA_LO, ioWrite);
  wire wrDataHi = hitWrite(ioAddr, `NPS_OFS_DATA_HI, ioWrite);
  wire wrAddrLo = hitWrite(ioAddr, `NPS_OFS_ADDR_LO, ioWrite);
  wire wrAddrHi = hitWrite(ioAddr, `NPS_OFS_ADDR_HI, ioWrite);

  ////////////////////////////////////////////////////////////////////////
  // protection bits

  wire lockWriteOne = wrProt && ioWrData[`NPS_BIT_BOOT_LOCK];
  // a one from outside the boot section is dropped
  wire lockAccepted = lockWriteOne && execInBoot;
  wire guardSet = wrProt && ioWrData[`NPS_BIT_APP_GUARD];

  always_comb begin
    next_lockState = lockState;
    case (lockState)
      NPS_LOCK_OPEN: begin
        if (lockAccepted) begin
          next_lockState = NPS_LOCK_ARMED;
        end
      end
      NPS_LOCK_ARMED: begin
        // waits for the first exit from the boot section
        if (!execInBoot) begin
          next_lockState = NPS_LOCK_ACTIVE;
        end
      end
      NPS_LOCK_ACTIVE: begin
        next_lockState = NPS_LOCK_ACTIVE;
      end
      default: begin
        next_lockState = NPS_LOCK_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      lockState <= NPS_LOCK_OPEN;
      appGuard <= 1'b0;
    end else begin
      lockState <= next_lockState;
      appGuard <= appGuard | guardSet;
    end
  end

  wire lockBit = (lockState != NPS_LOCK_OPEN);

  ////////////////////////////////////////////////////////////////////////
  // page buffer section tracking

  wire bufDrained = cmdStart &&
                    (cmdCode == NPS_CMD_PAGE_WRITE ||
                     cmdCode == NPS_CMD_ERASE_WRITE ||
                     cmdCode == NPS_CMD_BUF_CLEAR);
  wire bufConflict = pageBufWrite && bufUsed &&
                     (pageBufInBoot != bufInBoot);

  always_ff @(posedge clk) begin
    if (reset || bufDrained) begin
      bufUsed <= 1'b0;
      bufInBoot <= 1'b0;
      bufMixed <= 1'b0;
    end else if (pageBufWrite) begin
      bufUsed <= 1'b1;
      bufInBoot <= bufUsed ? bufInBoot : pageBufInBoot;
      bufMixed <= bufMixed | bufConflict;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command issue

  wire [2:0] reqCode = ioWrData[2:0];
  wire reqWritesPage = (reqCode == NPS_CMD_PAGE_WRITE) ||
                       (reqCode == NPS_CMD_ERASE_WRITE);
  wire reqTouchesApp = (reqWritesPage ||
                        reqCode == NPS_CMD_PAGE_ERASE) && targetIsApp;
  wire engineBusy = flashBusyIn || eepromBusyIn;
  wire reqLive = wrCommand && (reqCode != NPS_CMD_NONE) && !engineBusy;
  // fuse writes belong to the programming port alone
  wire fuseByCpu = (reqCode == NPS_CMD_FUSE_WRITE) && !progPortActive;
  wire refuseApp = appGuard && reqTouchesApp;
  wire refuseMix = reqWritesPage && bufMixed;
  wire reqRefused = reqLive && (refuseApp || refuseMix || fuseByCpu);
  wire reqAccepted = reqLive && !reqRefused;

  always_comb begin
    next_writeFault = writeFault;
    if (reqRefused) begin
      next_writeFault = 1'b1;
    end else if (reqAccepted) begin
      next_writeFault = 1'b0;
    end else if (opDone) begin
      next_writeFault = opFailed;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cmdStart <= 1'b0;
      cmdCode <= NPS_CMD_NONE;
      writeFault <= 1'b0;
    end else begin
      cmdStart <= reqAccepted;
      cmdCode <= reqAccepted ? nps_cmd_type'(reqCode) : cmdCode;
      writeFault <= next_writeFault;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status and eeprom ready

  wire readySet = !eepromBusyIn;
  wire readyClr = wrIrqPend && ioWrData[`NPS_BIT_EE_READY];

  // a ready condition in the clearing cycle keeps the flag set
  assign next_readyFlag = readySet | (readyFlag & ~readyClr);

  always_ff @(posedge clk) begin
    if (reset) begin
      flashBusyFlag <= 1'b0;
      eeBusyFlag <= 1'b0;
      readyIrqEnable <= 1'b0;
      readyFlag <= 1'b0;
      irqRequest <= 1'b0;
    end else begin
      flashBusyFlag <= flashBusyIn;
      eeBusyFlag <= eepromBusyIn;
      if (wrIrqEn) begin
        readyIrqEnable <= ioWrData[`NPS_BIT_EE_READY];
      end
      readyFlag <= next_readyFlag;
      irqRequest <= readyIrqEnable & next_readyFlag;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data and address pairs

  always_ff @(posedge clk) begin
    if (reset) begin
      writeValue <= `NPS_RESET_WORD;
      targetLocation <= `NPS_RESET_WORD;
    end else begin
      if (wrDataLo) begin
        writeValue[7:0] <= ioWrData;
      end
      if (wrDataHi) begin
        writeValue[15:8] <= ioWrData;
      end
      if (locUpdate) begin
        targetLocation <= locUpdateAddr;
      end else if (wrAddrLo) begin
        targetLocation[7:0] <= ioWrData;
      end else if (wrAddrHi) begin
        targetLocation[15:8] <= ioWrData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux

  wire [7:0] protByte = {6'h00, lockBit, appGuard};
  wire [7:0] stateByte = {5'h00, writeFault, eeBusyFlag, flashBusyFlag};
  wire [7:0] irqEnByte = {7'h00, readyIrqEnable};
  wire [7:0] irqPendByte = {7'h00, readyFlag};
  wire [7:0] readMux =
    (ioAddr == `NPS_OFS_PROT) ? protByte :
    (ioAddr == `NPS_OFS_STATE) ? stateByte :
    (ioAddr == `NPS_OFS_IRQ_EN) ? irqEnByte :
    (ioAddr == `NPS_OFS_IRQ_PEND) ? irqPendByte :
    (ioAddr == `NPS_OFS_DATA_LO) ? writeValue[7:0] :
    (ioAddr == `NPS_OFS_DATA_HI) ? writeValue[15:8] :
    (ioAddr == `NPS_OFS_ADDR_LO) ? targetLocation[7:0] :
    (ioAddr == `NPS_OFS_ADDR_HI) ? targetLocation[15:8] :
    `NPS_RESET_BYTE;

  always_ff @(posedge clk) begin
    if (reset) begin
      ioRdData <= `NPS_RESET_BYTE;
    end else begin
      ioRdData <= ioRead ? readMux : `NPS_RESET_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // boot section gating

  assign gif.lockActive = (lockState == NPS_LOCK_ACTIVE);
  assign gif.rdBoot = memRdBoot;
  assign gif.rdDataIn = memRdData;
  assign gif.fetchBoot = memFetchBoot;
  assign gif.fetchIn = memFetchWord;
  assign gatedRdData = gif.rdDataOut;
  assign gatedFetchWord = gif.fetchOut;

  nps_access_guard u_guard (
    .clk(clk),
    .reset(reset),
    .gd(gif.guard)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  lock_sticky_a: assert property (
    lockState != NPS_LOCK_OPEN |=> lockState != NPS_LOCK_OPEN)
    else $error("boot lock left set state without reset");

  lock_source_a: assert property (
    (lockWriteOne && !execInBoot && lockState == NPS_LOCK_OPEN)
    |=> lockState == NPS_LOCK_OPEN)
    else $error("boot lock taken from outside boot");

  lock_arming_a: assert property (
    (lockState == NPS_LOCK_ARMED && execInBoot) |=> !gif.lockActive)
    else $error("boot lock active before leaving boot");

  lock_engage_a: assert property (
    (lockState == NPS_LOCK_ARMED && !execInBoot) |=> gif.lockActive)
    else $error("boot lock not active after leaving boot");

  guard_hold_a: assert property (
    appGuard |=> appGuard)
    else $error("application guard cleared without reset");

  app_refuse_a: assert property (
    reqLive && refuseApp |=> !cmdStart && writeFault)
    else $error("protected application write not refused");

  mix_refuse_a: assert property (
    reqLive && refuseMix |=> !cmdStart && writeFault)
    else $error("mixed section page write not refused");

  cmd_issue_a: assert property (
    reqAccepted |=> cmdStart && cmdCode == $past(reqCode))
    else $error("accepted command not issued");

  busy_follow_a: assert property (
    eepromBusyIn |=> eeBusyFlag)
    else $error("eeprom busy flag missing");

  flash_follow_a: assert property (
    $fell(flashBusyIn) |=> !flashBusyFlag)
    else $error("flash busy flag not following");

  ready_level_a: assert property (
    (readyIrqEnable && !eepromBusyIn && !wrIrqEn) |=> irqRequest)
    else $error("eeprom ready request not asserted");

  ready_clear_a: assert property (
    (readyClr && eepromBusyIn) |=> !readyFlag ##0 !irqRequest)
    else $error("ready flag not cleared by one");

  loc_update_a: assert property (
    locUpdate |=> targetLocation == $past(locUpdateAddr))
    else $error("address not updated by controller");

endmodule
`default_nettype wire

// [inc/nps_map.svh]
// Function
// - boot lock blocks boot reads and fetches
// - locked boot reads and fetches return zero
// - lock written from boot only, reset clears
// - lock applies after first leaving boot
// - app guard refuses later application writes
// - app guard set-only, cleared by reset
// - write fault reflects last operation outcome
// - eeprom busy flag follows eeprom command
// - flash busy flag follows flash command
// - eeprom ready request is level, enable gated
// - enabled ready request asserts on second edge after enable write
// - ready flag cleared by writing one
// - data 0x06, address 0x08, high byte +1
// - address holds last updated memory location
// - command field decodes eight command codes
`ifndef NPS_MAP_SVH
`define NPS_MAP_SVH

`define NPS_OFS_COMMAND 4'h0
`define NPS_OFS_PROT 4'h1
`define NPS_OFS_STATE 4'h2
`define NPS_OFS_IRQ_EN 4'h3
`define NPS_OFS_IRQ_PEND 4'h4
`define NPS_OFS_DATA_LO 4'h6
`define NPS_OFS_DATA_HI 4'h7
`define NPS_OFS_ADDR_LO 4'h8
`define NPS_OFS_ADDR_HI 4'h9

`define NPS_BIT_APP_GUARD 0
`define NPS_BIT_BOOT_LOCK 1
`define NPS_BIT_FLASH_BUSY 0
`define NPS_BIT_EE_BUSY 1
`define NPS_BIT_WR_FAULT 2
`define NPS_BIT_EE_READY 0

`define NPS_RESET_BYTE 8'h00
`define NPS_RESET_WORD 16'h0000

`endif

// [inc/nps_pkg.sv]
package nps_pkg;

  typedef enum logic [2:0] {
    NPS_CMD_NONE = 3'h0,
    NPS_CMD_PAGE_WRITE = 3'h1,
    NPS_CMD_PAGE_ERASE = 3'h2,
    NPS_CMD_ERASE_WRITE = 3'h3,
    NPS_CMD_BUF_CLEAR = 3'h4,
    NPS_CMD_CHIP_ERASE = 3'h5,
    NPS_CMD_EE_ERASE = 3'h6,
    NPS_CMD_FUSE_WRITE = 3'h7
  } nps_cmd_type;

  typedef enum logic [1:0] {
    NPS_LOCK_OPEN = 2'h0,
    NPS_LOCK_ARMED = 2'h1,
    NPS_LOCK_ACTIVE = 2'h2
  } nps_lock_type;

endpackage

// [inc/nps_guard_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface nps_guard_if;
  logic lockActive;
  logic rdBoot;
  logic [7:0] rdDataIn;
  logic [7:0] rdDataOut;
  logic fetchBoot;
  logic [15:0] fetchIn;
  logic [15:0] fetchOut;

  modport owner (
    output lockActive, rdBoot, rdDataIn, fetchBoot, fetchIn,
    input rdDataOut, fetchOut
  );
  modport guard (
    input lockActive, rdBoot, rdDataIn, fetchBoot, fetchIn,
    output rdDataOut, fetchOut
  );
endinterface
`default_nettype wire

// [core/nps_access_guard.sv]
`timescale 1ns/1ps
`default_nettype none
module nps_access_guard (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // gated memory paths
  nps_guard_if.guard gd
);

  wire blockRead = gd.lockActive && gd.rdBoot;
  wire blockFetch = gd.lockActive && gd.fetchBoot;

  always_ff @(posedge clk) begin
    if (reset) begin
      gd.rdDataOut <= 8'h00;
      gd.fetchOut <= 16'h0000;
    end else begin
      gd.rdDataOut <= blockRead ? 8'h00 : gd.rdDataIn;
      gd.fetchOut <= blockFetch ? 16'h0000 : gd.fetchIn;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  locked_read_a: assert property (blockRead |=> gd.rdDataOut == 8'h00)
    else $error("locked boot read not zero");
  locked_fetch_a: assert property (
    blockFetch |=> gd.fetchOut == 16'h0000)
    else $error("locked boot fetch not zero");
  open_read_a: assert property (
    !gd.lockActive |=> gd.rdDataOut == $past(gd.rdDataIn))
    else $error("unlocked read altered");

endmodule
`default_nettype wire

// [verification/nps_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module nps_cpu_model (
  // clock
  input wire logic clk,
  // i/o bus
  output logic [3:0] ioAddr,
  output logic [7:0] ioWrData,
  output logic ioWrite,
  output logic ioRead,
  input wire logic [7:0] ioRdData,
  // execution context
  output logic execInBoot,
  output logic progPortActive
);
  initial begin
    {ioAddr, ioWrData, ioWrite, ioRead} = 14'h0;
    {execInBoot, progPortActive} = 2'h0;
  end

  // released lines show the inverse so stale values cannot pass
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    ioAddr = a;
    ioWrData = d;
    ioWrite = 1'b1;
    @(negedge clk);
    ioWrite = 1'b0;
    ioWrData = ~d;
    ioAddr = ~a;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk);
    ioAddr = a;
    ioRead = 1'b1;
    @(negedge clk);
    ioRead = 1'b0;
    ioAddr = ~a;
    d = ioRdData;
  endtask

  task automatic setCtx(input logic b, input logic p);
    @(negedge clk);
    execInBoot = b;
    progPortActive = p;
  endtask

  // programming port: address first, then value; command follows
  task automatic fuseLoad(input logic [15:0] a, input logic [15:0] d);
    setCtx(execInBoot, 1'b1);
    wr(4'h8, a[7:0]);
    wr(4'h9, a[15:8]);
    wr(4'h6, d[7:0]);
    wr(4'h7, d[15:8]);
  endtask

  // handler turns the level request off
  task automatic readyHandler();
    wr(4'h3, 8'h00);
  endtask
endmodule
`default_nettype wire

// [verification/nps_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module nps_regs_tb;
  import nps_pkg::*;
  logic clk, reset, ioWrite, ioRead, execInBoot, progPortActive;
  logic [3:0] ioAddr;
  logic [7:0] ioWrData, ioRdData, memRdData, gatedRdData;
  logic pageBufWrite, pageBufInBoot, targetIsApp, flashBusyIn;
  logic eepromBusyIn, opDone, opFailed, locUpdate, cmdStart;
  logic memRdBoot, memFetchBoot, irqRequest;
  logic [15:0] locUpdateAddr, memFetchWord, gatedFetchWord;
  nps_cmd_type cmdCode;
  integer seed = 32'hD39E6353;
  int errTotal = 0, totalChecks = 0;
  int mLock, mGuard, mFault, mEn, mFlag, mFb, mEb, lastCmd;
  int mW [2];
  logic [15:0] fa, fd;

  nps_cpu_model u_cpu (.clk(clk), .ioAddr(ioAddr), .ioWrData(ioWrData),
    .ioWrite(ioWrite), .ioRead(ioRead), .ioRdData(ioRdData),
    .execInBoot(execInBoot), .progPortActive(progPortActive));

  nps_regs u_dut (.clk(clk), .reset(reset), .ioAddr(ioAddr),
    .ioWrData(ioWrData), .ioWrite(ioWrite), .ioRead(ioRead),
    .ioRdData(ioRdData), .execInBoot(execInBoot),
    .progPortActive(progPortActive), .pageBufWrite(pageBufWrite),
    .pageBufInBoot(pageBufInBoot), .targetIsApp(targetIsApp),
    .flashBusyIn(flashBusyIn), .eepromBusyIn(eepromBusyIn),
    .opDone(opDone), .opFailed(opFailed), .locUpdate(locUpdate),
    .locUpdateAddr(locUpdateAddr), .cmdCode(cmdCode),
    .cmdStart(cmdStart), .memRdBoot(memRdBoot), .memRdData(memRdData),
    .memFetchBoot(memFetchBoot), .memFetchWord(memFetchWord),
    .gatedRdData(gatedRdData), .gatedFetchWord(gatedFetchWord),
    .irqRequest(irqRequest));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] expRead(input int a);
    case (a)
      1: return {6'h00, 1'(mLock > 0), 1'(mGuard)};
      2: return {5'h00, 1'(mFault), 1'(mEb), 1'(mFb)};
      3: return 8'(mEn);
      4: return 8'(mFlag);
      6, 7, 8, 9: return 8'(mW[(a - 6) / 2] >> (8 * (a % 2)));
      default: return 8'h00;
    endcase
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkReg(input int a);
    logic [7:0] d;
    u_cpu.rd(4'(a), d);
    chk(16'(d), 16'(expRead(a)));
  endtask

  // ok: 1 accepted, 0 refused with fault, 2 silently ignored
  task automatic cmd(input logic [2:0] c, input int ok);
    u_cpu.wr(4'h0, {5'h00, c});
    chk(16'(cmdStart), 16'(ok == 1));
    if (ok == 1)
      lastCmd = c;
    if (ok < 2)
      mFault = (ok == 0);
    chk(16'(cmdCode), 16'(lastCmd));
  endtask

  task automatic doReset();
    reset = 1'b1;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    {mLock, mGuard, mFault, mEn, mFb, mEb, lastCmd} = '0;
    mW = '{0, 0};
    mFlag = 1;
  endtask

  task automatic pulse(input int kind, input logic b);
    @(negedge clk);
    if (kind == 0)
      {pageBufWrite, pageBufInBoot} = {1'b1, b};
    else
      {opDone, opFailed} = {1'b1, b};
    @(negedge clk);
    {pageBufWrite, opDone, pageBufInBoot, opFailed} = {2'b00, ~b, ~b};
  endtask

  task automatic gate(input logic b, input int z);
    logic [7:0] d;
    logic [15:0] w;
    d = 8'($random(seed));
    w = 16'($random(seed));
    @(negedge clk);
    {memRdBoot, memFetchBoot, memRdData, memFetchWord} = {b, b, d, w};
    @(negedge clk);
    chk(16'(gatedRdData), z ? 16'h0 : 16'(d));
    chk(gatedFetchWord, z ? 16'h0 : w);
  endtask

  task automatic testDone();
    $display("checks %0d errors %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    testDone();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {pageBufWrite, pageBufInBoot, targetIsApp, opDone, opFailed} = 5'h00;
    {flashBusyIn, eepromBusyIn, locUpdate, memRdBoot, memFetchBoot} = 5'h00;
    {locUpdateAddr, memFetchWord, memRdData} = 40'h0;
    doReset();
    for (int a = 0; a < 16; a++) chkReg(a);
    u_cpu.wr(4'h2, 8'hFF);
    chkReg(2);
    for (int a = 6; a < 10; a++) begin
      fd = 16'($random(seed));
      u_cpu.wr(4'(a), fd[7:0]);
      mW[(a - 6) / 2][8 * (a % 2) +: 8] = fd[7:0];
    end
    for (int a = 6; a < 10; a++) chkReg(a);
    fa = 16'($random(seed));
    @(negedge clk);
    {locUpdate, locUpdateAddr} = {1'b1, fa};
    @(negedge clk);
    locUpdate = 1'b0;
    mW[1] = fa;
    chkReg(8);
    chkReg(9);
    u_cpu.wr(4'h1, 8'h00);
    chkReg(1);
    u_cpu.wr(4'h1, 8'h01);
    mGuard = 1;
    u_cpu.wr(4'h1, 8'h00);
    chkReg(1);
    targetIsApp = 1'b1;
    for (int c = 1; c < 4; c++) cmd(3'(c), 0);
    chkReg(2);
    cmd(3'h4, 1);
    targetIsApp = 1'b0;
    for (int c = 1; c < 7; c++) cmd(3'(c), 1);
    cmd(3'h0, 2);
    cmd(3'h7, 0);
    pulse(0, 1'b0);
    pulse(0, 1'b1);
    cmd(3'h1, 0);
    cmd(3'h4, 1);
    cmd(3'h3, 1);
    fd = 16'($random(seed));
    u_cpu.fuseLoad(fa ^ 16'h00FF, fd);
    mW = '{fd, fa ^ 16'h00FF};
    cmd(3'h7, 1);
    u_cpu.setCtx(1'b0, 1'b0);
    for (int a = 6; a < 10; a++) chkReg(a);
    pulse(1, 1'b1);
    mFault = 1;
    chkReg(2);
    pulse(1, 1'b0);
    mFault = 0;
    chkReg(2);
    flashBusyIn = 1'b1;
    mFb = 1;
    cmd(3'h4, 2);
    chkReg(2);
    flashBusyIn = 1'b0;
    mFb = 0;
    u_cpu.wr(4'h3, 8'h01);
    mEn = 1;
    @(negedge clk);
    chk(16'(irqRequest), 16'h1);
    eepromBusyIn = 1'b1;
    mEb = 1;
    u_cpu.wr(4'h4, 8'h00);
    chkReg(4);
    u_cpu.wr(4'h4, 8'h01);
    mFlag = 0;
    chkReg(4);
    chk(16'(irqRequest), 16'h0);
    chkReg(2);
    eepromBusyIn = 1'b0;
    mEb = 0;
    mFlag = 1;
    repeat (2) @(negedge clk);
    chk(16'(irqRequest), 16'h1);
    u_cpu.readyHandler();
    mEn = 0;
    @(negedge clk);
    chk(16'(irqRequest), 16'h0);
    u_cpu.wr(4'h1, 8'h02);
    chkReg(1);
    u_cpu.setCtx(1'b1, 1'b0);
    u_cpu.wr(4'h1, 8'h02);
    mLock = 1;
    chkReg(1);
    gate(1'b1, 0);
    u_cpu.setCtx(1'b0, 1'b0);
    mLock = 2;
    gate(1'b1, 1);
    gate(1'b0, 0);
    u_cpu.wr(4'h1, 8'h00);
    chkReg(1);
    doReset();
    gate(1'b1, 0);
    for (int a = 0; a < 16; a++) chkReg(a);
    testDone();
  end
endmodule
`default_nettype wire
